/* File: core/arlt_pkg.sv */
package arlt_pkg;

	// Count clock source codes
	localparam logic [1:0] ARLT_SRC_CORE     = 2'h0;  // Core clock
	localparam logic [1:0] ARLT_SRC_CORE_D12 = 2'h1;  // Core clock divided by 12
	localparam logic [1:0] ARLT_SRC_EXT_D8   = 2'h2;  // External oscillator / 8
	localparam logic [1:0] ARLT_SRC_LFO_D8   = 2'h3;  // Low-frequency oscillator / 8

	// Timing counts
	localparam int unsigned ARLT_CORE_DIV    = 12;    // Prescaler ratio for the slow core source
	localparam logic [3:0]  ARLT_PRE_LAST    = 4'(ARLT_CORE_DIV - 1);
	localparam logic [1:0]  ARLT_SYNC_TICKS  = 2'h3;  // Timer clocks of busy after foreign wake

	// Reset values
	localparam logic [7:0]  ARLT_BYTE_RST    = 8'h00; // Counter and reload bytes
	localparam logic [7:0]  ARLT_BYTE_MAX    = 8'hff; // Byte value that wraps

	// Software byte access
	typedef struct packed {
		logic       wrCntLow;   // Write count_low_byte
		logic       wrCntHigh;  // Write count_high_byte
		logic       wrRldLow;   // Write reload_low_byte
		logic       wrRldHigh;  // Write reload_high_byte
		logic [7:0] wrData;     // Byte to write
	} arlt_wr_t;

	// Control and configuration bits
	typedef struct packed {
		logic       splitModeSelect;  // 1: two 8-bit counters
		logic       lowByteIrqEnable; // Low byte wrap also interrupts
		logic       timerIrqEnable;   // Timer interrupt enable
		logic [1:0] clkSel;           // Count clock source
		logic       clrHighOvf;       // Clear high overflow flag
		logic       clrLowOvf;        // Clear low overflow flag
	} arlt_ctl_t;

	// Counter and reload bytes as seen by software
	typedef struct packed {
		logic [7:0] countHighByte;
		logic [7:0] countLowByte;
		logic [7:0] reloadHighByte;
		logic [7:0] reloadLowByte;
	} arlt_rd_t;

endpackage : arlt_pkg

/* File: core/arlt_timer.sv */
// Behaviour
// - 16-bit count held as two bytes
// - Split bit chooses 16-bit or two 8-bit
// - Four selectable count clock sources
// - Slow clocks synchronised, direct in suspend
// - Counts in suspend, overflow wakes device
// - Busy flag up to three ticks after wake
// - 16-bit wrap reloads and sets high flag
// - Interrupt on high overflow when enabled
// - Low byte wrap interrupts when enabled
`timescale 1ns/100ps
`default_nettype none

module arlt_timer
	import arlt_pkg::*;
(
	input  wire logic      mclk,          // Core clock, 200 MHz
	input  wire logic      rst_n,         // Synchronous reset, active low
	input  wire arlt_wr_t  swWr,          // Software byte writes
	input  wire arlt_ctl_t ctl,           // Control bits
	input  wire logic      extOscDiv8,    // External oscillator / 8, asynchronous
	input  wire logic      lfoDiv8,       // Low-freq oscillator / 8, asynchronous
	input  wire logic      suspend,       // Device is in suspend
	input  wire logic      wakeOther,     // Pulse: wake by a source other than timer
	output arlt_rd_t       swRd,          // Counter and reload bytes
	output logic           highOvfFlag,   // High byte overflow flag
	output logic           lowOvfFlag,    // Low byte overflow flag
	output logic           irqReq,        // Interrupt request level
	output logic           wakeReq,       // Pulse: overflow ends suspend
	output logic           suspendSyncBusyFlag // Counter registers not safe
);

	// Synchroniser and edge state for slow sources
	logic [1:0] extSync_r, extSync_nxt;    // Two-stage sync of external clock
	logic [1:0] lfoSync_r, lfoSync_nxt;    // Two-stage sync of LOW_FREQ_OSCILLATOR clock
	logic       extPrev_r, extPrev_nxt;    // Extra stage for edge detect
	logic       lfoPrev_r, lfoPrev_nxt;
	logic       extPrev_q, extPrev_q_nxt;  // Third-stage history, external
	logic       lfoPrev_q, lfoPrev_q_nxt;  // Third-stage history, LOW_FREQ_OSCILLATOR
	logic [3:0] pre_r,     pre_nxt;        // Divide-by-12 prescaler
	logic       tick;                      // One count clock this cycle

	// Only stage 2 of each synchroniser feeds logic
	always_comb begin
		extSync_nxt = {extSync_r[0], extOscDiv8};
		lfoSync_nxt = {lfoSync_r[0], lfoDiv8};
		extPrev_nxt = extSync_r[1];
		lfoPrev_nxt = lfoSync_r[1];
		pre_nxt     = (pre_r == ARLT_PRE_LAST) ? 4'h0 : pre_r + 4'h1;
	end

	// Source select and edge detect
	always_comb begin
		unique case (ctl.clkSel)
			ARLT_SRC_CORE:     tick = 1'b1;
			ARLT_SRC_CORE_D12: tick = (pre_r == ARLT_PRE_LAST);
			// Outside suspend the edge waits one more stage; in suspend the
			// synchronised level is used straight, trading a cycle of margin
			// for wake latency while the core clock is slow or gated.
			ARLT_SRC_EXT_D8: begin
				if (suspend) begin
					tick = extSync_r[1] & ~extPrev_r;
				end else begin
					tick = extPrev_r & ~extPrev_q;
				end
			end
			// LOW_FREQ_OSCILLATOR / 8 source, edge detected the same way as the external source
			ARLT_SRC_LFO_D8: begin
				if (suspend) begin
					tick = lfoSync_r[1] & ~lfoPrev_r;
				end else begin
					tick = lfoPrev_r & ~lfoPrev_q;
				end
			end
		endcase
	end

	// Third-stage history for the non-suspend edge
	always_comb begin
		extPrev_q_nxt = extPrev_r;
		lfoPrev_q_nxt = lfoPrev_r;
	end

	// Register the clocking front end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			extSync_r <= 2'h0;
			lfoSync_r <= 2'h0;
			extPrev_r <= 1'b0;
			lfoPrev_r <= 1'b0;
			extPrev_q <= 1'b0;
			lfoPrev_q <= 1'b0;
			pre_r     <= 4'h0;
		end else begin
			extSync_r <= extSync_nxt;
			lfoSync_r <= lfoSync_nxt;
			extPrev_r <= extPrev_nxt;
			lfoPrev_r <= lfoPrev_nxt;
			extPrev_q <= extPrev_q_nxt;
			lfoPrev_q <= lfoPrev_q_nxt;
			pre_r     <= pre_nxt;
		end
	end

	// Counter, reload and flag state
	logic [7:0] cntLo_r, cntLo_nxt;     // count_low_byte
	logic [7:0] cntHi_r, cntHi_nxt;     // count_high_byte
	logic [7:0] rldLo_r, rldLo_nxt;     // reload_low_byte
	logic [7:0] rldHi_r, rldHi_nxt;     // reload_high_byte
	logic       hiFlag_r, hiFlag_nxt;   // High overflow flag
	logic       loFlag_r, loFlag_nxt;   // Low overflow flag
	logic       wake_r, wake_nxt;       // Wake pulse
	logic       busy_r, busy_nxt;       // Sync busy flag
	logic [1:0] busyCnt_r, busyCnt_nxt; // Timer clocks left while busy
	logic       loWrap;                 // Low byte wraps this tick
	logic       hiWrap;                 // High byte or full count wraps
	logic       wrOk;                   // Software write accepted

	// Next counter values
	always_comb begin
		loWrap    = tick & (cntLo_r == ARLT_BYTE_MAX);
		cntLo_nxt = cntLo_r;
		cntHi_nxt = cntHi_r;
		if (ctl.splitModeSelect) begin
			hiWrap = tick & (cntHi_r == ARLT_BYTE_MAX);
			if (tick) begin
				cntLo_nxt = loWrap ? rldLo_r : cntLo_r + 8'h01;
				cntHi_nxt = hiWrap ? rldHi_r : cntHi_r + 8'h01;
			end
		end else begin
			hiWrap = loWrap & (cntHi_r == ARLT_BYTE_MAX);
			if (hiWrap) begin
				cntLo_nxt = rldLo_r;
				cntHi_nxt = rldHi_r;
			end else if (tick) begin
				{cntHi_nxt, cntLo_nxt} = {cntHi_r, cntLo_r} + 16'h0001;
			end
		end
		// Writes refused while the sync is unsafe; write beats a tick
		wrOk = ~busy_r;
		if (wrOk & swWr.wrCntLow) begin
			cntLo_nxt = swWr.wrData;
		end
		if (wrOk & swWr.wrCntHigh) begin
			cntHi_nxt = swWr.wrData;
		end
		rldLo_nxt = (wrOk & swWr.wrRldLow)  ? swWr.wrData : rldLo_r;
		rldHi_nxt = (wrOk & swWr.wrRldHigh) ? swWr.wrData : rldHi_r;
	end

	// Next flag, wake and busy values
	always_comb begin
		// Set wins over a clear in the same cycle
		hiFlag_nxt = hiWrap | (hiFlag_r & ~ctl.clrHighOvf);
		loFlag_nxt = loWrap | (loFlag_r & ~ctl.clrLowOvf);
		wake_nxt   = suspend & hiWrap;
		busy_nxt    = busy_r;
		busyCnt_nxt = busyCnt_r;
		if (wakeOther) begin
			busy_nxt    = 1'b1;
			busyCnt_nxt = ARLT_SYNC_TICKS;
		end else if (busy_r & tick) begin
			busyCnt_nxt = busyCnt_r - 2'h1;
			busy_nxt    = (busyCnt_r != 2'h1);
		end
	end

	// Register counter and flag state
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cntLo_r   <= ARLT_BYTE_RST;
			cntHi_r   <= ARLT_BYTE_RST;
			rldLo_r   <= ARLT_BYTE_RST;
			rldHi_r   <= ARLT_BYTE_RST;
			hiFlag_r  <= 1'b0;
			loFlag_r  <= 1'b0;
			wake_r    <= 1'b0;
			busy_r    <= 1'b0;
			busyCnt_r <= 2'h0;
		end else begin
			cntLo_r   <= cntLo_nxt;
			cntHi_r   <= cntHi_nxt;
			rldLo_r   <= rldLo_nxt;
			rldHi_r   <= rldHi_nxt;
			hiFlag_r  <= hiFlag_nxt;
			loFlag_r  <= loFlag_nxt;
			wake_r    <= wake_nxt;
			busy_r    <= busy_nxt;
			busyCnt_r <= busyCnt_nxt;
		end
	end

	// Outputs
	always_comb begin
		swRd                = '{cntHi_r, cntLo_r, rldHi_r, rldLo_r};
		highOvfFlag         = hiFlag_r;
		lowOvfFlag          = loFlag_r;
		// Level request held until software clears the flag
		irqReq              = ctl.timerIrqEnable &
		                      (hiFlag_r | (ctl.lowByteIrqEnable & loFlag_r));
		wakeReq             = wake_r;
		suspendSyncBusyFlag = busy_r;
	end

endmodule : arlt_timer

`default_nettype wire

/* File: verif/arlt_timer_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module arlt_timer_checker
	import arlt_pkg::*;
(
	input wire logic      mclk,                // Core clock
	input wire logic      rst_n,               // Synchronous reset, active low
	input wire arlt_wr_t  swWr,                // Software byte writes
	input wire arlt_ctl_t ctl,                 // Control bits
	input wire logic      extOscDiv8,          // External slow clock
	input wire logic      lfoDiv8,             // Low-freq slow clock
	input wire logic      suspend,             // Suspend level
	input wire logic      wakeOther,           // Foreign wake pulse
	input wire arlt_rd_t  swRd,                // Counter and reload bytes
	input wire logic      highOvfFlag,         // High overflow flag
	input wire logic      lowOvfFlag,          // Low overflow flag
	input wire logic      irqReq,              // Interrupt request
	input wire logic      wakeReq,             // Wake pulse
	input wire logic      suspendSyncBusyFlag  // Busy flag
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Core ticks every edge and software leaves the bytes alone
	logic quiet;
	assign quiet = (ctl.clkSel == ARLT_SRC_CORE) && (swWr[11:8] == 4'h0);

	a_irq_level: assert property (irqReq == (ctl.timerIrqEnable & (highOvfFlag | (ctl.lowByteIrqEnable & lowOvfFlag))))
		else $error("irq level wrong");
	a_write_low: assert property (swWr.wrCntLow && !suspendSyncBusyFlag |=> swRd.countLowByte == $past(swWr.wrData))
		else $error("low byte write lost");
	a_write_reload: assert property (swWr.wrRldHigh && !suspendSyncBusyFlag |=> swRd.reloadHighByte == $past(swWr.wrData))
		else $error("reload write lost");
	a_busy_blocks: assert property (suspendSyncBusyFlag && swWr.wrRldLow |=> $stable(swRd.reloadLowByte))
		else $error("write taken while busy");
	a_count_step: assert property (quiet && swRd.countLowByte != ARLT_BYTE_MAX |=> swRd.countLowByte == $past(swRd.countLowByte) + 8'h01)
		else $error("count did not step");
	a_high_hold: assert property (quiet && !ctl.splitModeSelect && swRd.countLowByte != ARLT_BYTE_MAX |=> $stable(swRd.countHighByte))
		else $error("high byte moved early");
	a_wrap_reload: assert property (quiet && !ctl.splitModeSelect && {swRd.countHighByte, swRd.countLowByte} == 16'hffff
		|=> {swRd.countHighByte, swRd.countLowByte} == $past({swRd.reloadHighByte, swRd.reloadLowByte}) && highOvfFlag)
		else $error("16-bit wrap wrong");
	a_split_reload: assert property (quiet && ctl.splitModeSelect && swRd.countLowByte == ARLT_BYTE_MAX
		|=> swRd.countLowByte == $past(swRd.reloadLowByte) && lowOvfFlag)
		else $error("split wrap wrong");
	a_wake_cause: assert property (wakeReq |-> $past(suspend) && highOvfFlag)
		else $error("wake without overflow");
	a_busy_set: assert property (wakeOther |=> suspendSyncBusyFlag)
		else $error("busy not set");
	a_busy_bound: assert property (wakeOther ##1 (!wakeOther && ctl.clkSel == ARLT_SRC_CORE)[*3] |=> !suspendSyncBusyFlag)
		else $error("busy too long");
endmodule : arlt_timer_checker

bind arlt_timer arlt_timer_checker chk_i (.mclk(mclk), .rst_n(rst_n), .swWr(swWr), .ctl(ctl),
	.extOscDiv8(extOscDiv8), .lfoDiv8(lfoDiv8), .suspend(suspend), .wakeOther(wakeOther), .swRd(swRd),
	.highOvfFlag(highOvfFlag), .lowOvfFlag(lowOvfFlag), .irqReq(irqReq), .wakeReq(wakeReq),
	.suspendSyncBusyFlag(suspendSyncBusyFlag));
`default_nettype wire

/* File: verif/auto_reload_timer_with_suspend_wake_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module auto_reload_timer_with_suspend_wake_tb;
	import arlt_pkg::*;
	logic        mclk, rst_n, extOscDiv8, lfoDiv8, suspend, wakeOther; // Driven pins
	arlt_wr_t    swWr;                                                 // Byte writes
	arlt_ctl_t   ctl;                                                  // Control bits
	arlt_rd_t    swRd;                                                 // Readback
	logic        highOvfFlag, lowOvfFlag, irqReq, wakeReq, busy;       // Observed
	logic [31:0] seed;                                                 // Random state
	logic [15:0] rld;                                                  // Reload pair
	int          bad_count, checks, wakes, w0;                         // Tallies

	arlt_timer uut (.mclk(mclk), .rst_n(rst_n), .swWr(swWr), .ctl(ctl), .extOscDiv8(extOscDiv8),
		.lfoDiv8(lfoDiv8), .suspend(suspend), .wakeOther(wakeOther), .swRd(swRd), .highOvfFlag(highOvfFlag),
		.lowOvfFlag(lowOvfFlag), .irqReq(irqReq), .wakeReq(wakeReq), .suspendSyncBusyFlag(busy));

	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Counts wake pulses
	always @(posedge mclk) if (wakeReq === 1'b1) wakes <= wakes + 1;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Expected 16-bit count after n ticks
	function automatic logic [15:0] exp16(input logic [15:0] c, input logic [15:0] r, input int n);
		repeat (n) c = (c == 16'hffff) ? r : c + 16'h0001;
		return c;
	endfunction : exp16

	// Inputs change 1 ns after the edge
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One-cycle strobe, then an idle edge so strobes never merge
	task automatic wr(input logic [3:0] sel, input logic [7:0] d);
		swWr = {sel, d};
		step(1);
		swWr = '0;
		step(1);
	endtask : wr

	task automatic load(input logic [15:0] c, input logic [15:0] r);
		wr(4'h8, c[7:0]);
		wr(4'h4, c[15:8]);
		wr(4'h2, r[7:0]);
		wr(4'h1, r[15:8]);
	endtask : load

	// Slow pulses held 4 edges so the synchroniser sees them
	task automatic pulse(input logic low_freq_oscillator, input int n);
		repeat (n) begin
			if (low_freq_oscillator) lfoDiv8 = 1'b1;
			else extOscDiv8 = 1'b1;
			step(4);
			{lfoDiv8, extOscDiv8} = 2'b00;
			step(4);
		end
	endtask : pulse

	task automatic end_of_test;
		if (bad_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	// Idle low-freq pin freezes the count while loading
	initial begin
		{seed, bad_count, checks, wakes} = {32'h6e98, 96'h0};
		{rst_n, extOscDiv8, lfoDiv8, suspend, wakeOther} = 5'h0;
		swWr = '0;
		ctl = '0;
		ctl.clkSel = ARLT_SRC_LFO_D8;
		step(10);
		rst_n = 1'b1;
		chk({swRd, highOvfFlag, lowOvfFlag, irqReq, busy}, 32'h0);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			load(seed[31:16], seed[15:0]);
			chk(swRd, seed);
		end
		rld = seed[15:0];
		load(16'hfffd, rld);
		ctl.timerIrqEnable = 1'b1;
		ctl.clkSel = ARLT_SRC_CORE;
		step(3);
		ctl.clkSel = ARLT_SRC_LFO_D8;
		chk({swRd[31:16], highOvfFlag, lowOvfFlag, irqReq}, {exp16(16'hfffd, rld, 3), 3'b111});
		{ctl.clrHighOvf, ctl.clrLowOvf, ctl.splitModeSelect} = 3'b111;
		step(1);
		{ctl.clrHighOvf, ctl.clrLowOvf} = 2'b00;
		load(16'h10ff, rld);
		ctl.clkSel = ARLT_SRC_CORE;
		step(1);
		ctl.clkSel = ARLT_SRC_LFO_D8;
		chk({swRd[31:16], highOvfFlag, lowOvfFlag, irqReq}, {8'h11, rld[7:0], 3'b010});
		ctl.lowByteIrqEnable = 1'b1;
		#1 chk(irqReq, 1'b1);
		ctl.splitModeSelect = 1'b0;
		load(16'h0100, rld);
		ctl.clkSel = ARLT_SRC_CORE_D12;
		step(24);
		ctl.clkSel = ARLT_SRC_EXT_D8;
		pulse(1'b0, 3);
		pulse(1'b1, 1);
		ctl.clkSel = ARLT_SRC_LFO_D8; // Pin stands for a LOW_FREQ_OSCILLATOR divided by 8
		pulse(1'b1, 2);
		pulse(1'b0, 1);
		chk(swRd[31:16], exp16(16'h0100, rld, 7));
		load(16'hfffe, rld);
		{suspend, w0, ctl.clkSel} = {1'b1, wakes, ARLT_SRC_EXT_D8};
		pulse(1'b0, 2);
		chk({16'(wakes - w0), swRd[31:16]}, {16'h1, rld});
		suspend = 1'b0;
		ctl.clkSel = ARLT_SRC_CORE;
		wakeOther = 1'b1;
		step(1);
		wakeOther = 1'b0;
		chk(busy, 1'b1);
		wr(4'h2, ~rld[7:0]);
		step(1);
		chk({busy, swRd.reloadLowByte}, {1'b0, rld[7:0]});
		end_of_test();
	end
endmodule : auto_reload_timer_with_suspend_wake_tb
`default_nettype wire
